// ===== logic/dscp_regs.svh
// field positions, codes, reset values and timing of the dac serial command port
`ifndef DSCP_REGS_SVH
`define DSCP_REGS_SVH

`define DSCP_WORD_BITS 24
`define DSCP_MODE_HI 23
`define DSCP_MODE_LO 22
`define DSCP_ADDR_HI 21
`define DSCP_ADDR_LO 16
`define DSCP_DATA_HI 15
`define DSCP_DATA_LO 2
`define DSCP_RSVD_BITS 2
`define DSCP_FUNC_HI 15
`define DSCP_FUNC_LO 0

`define DSCP_MODE_SPECIAL 2'h0
`define DSCP_MODE_GAIN 2'h1
`define DSCP_MODE_OFFSET 2'h2
`define DSCP_MODE_INPUT 2'h3

`define DSCP_FN_NOP 6'h00
`define DSCP_FN_CTRL 6'h01
`define DSCP_FN_SPAN_OFFSET_DAC_0 6'h02
`define DSCP_FN_SPAN_OFFSET_DAC_2 6'h04
`define DSCP_FN_READBACK 6'h05
`define DSCP_FN_ABSEL0 6'h06
`define DSCP_FN_ABSEL4 6'h0a
`define DSCP_FN_ABSEL_ALL 6'h0b

`define DSCP_CTRL_BANK_BIT 2
`define DSCP_CTRL_THERM_BIT 1
`define DSCP_CTRL_PD_BIT 0

`define DSCP_RB_TYPE_HI 15
`define DSCP_RB_TYPE_LO 13
`define DSCP_RB_CHAN_HI 12
`define DSCP_RB_CHAN_LO 7
`define DSCP_RB_CHAN_BASE 6'h08
`define DSCP_RB_SPEC_SPAN_OFFSET_DAC_0 6'h01
`define DSCP_RB_SPEC_ABSEL0 6'h04

`define DSCP_NUM_CHAN 40
`define DSCP_NUM_GROUP 5
`define DSCP_GROUP_CHAN 8
`define DSCP_INPUT_RST 14'h0000
`define DSCP_OFFSET_RST 14'h2000
`define DSCP_GAIN_RST 14'h3fff
`define DSCP_OFSDAC_RST 14'h0000

`define DSCP_MCLK_PS 5000
`define DSCP_T_STAGE1_NS 500
`define DSCP_T_STAGE2_NS 500
`define DSCP_T_STAGE3_NS 250
`define DSCP_CYC_MIN(ns) (((ns) * 1000 + `DSCP_MCLK_PS - 1) / `DSCP_MCLK_PS)

`endif

// ===== logic/dscp_pkg.sv
// types shared by the dac serial command port
`default_nettype none
package dscp_pkg;
  typedef enum logic [1:0] {DSCP_CALC_IDLE, DSCP_CALC_ST1, DSCP_CALC_ST2, DSCP_CALC_ST3} dscp_calc_state_t;
  typedef enum logic [2:0] {DSCP_RB_A, DSCP_RB_B, DSCP_RB_C, DSCP_RB_M, DSCP_RB_SPEC} dscp_rb_type_t;
endpackage : dscp_pkg
`default_nettype wire

// ===== logic/dscp_link_rx.sv
// link-side shifter running on the host shift clock
`timescale 1ns/1ps
`default_nettype none
`include "dscp_regs.svh"
module dscp_link_rx #(
  parameter int unsigned WORD_BITS = `DSCP_WORD_BITS
) (
  input wire logic sclk,
  input wire logic rst_b,
  input wire logic frame_n,
  input wire logic data_in,
  input wire logic [WORD_BITS-1:0] rb_word,
  output logic [WORD_BITS-1:0] word_hold,
  output logic done_tgl,
  output logic serial_out
);
  logic [4:0] cnt_r;
  logic [WORD_BITS-1:0] shift_r;

  ////////////////////////////////////////////////////////////////////////////////
  // frame high clears the count, so edges outside a frame do nothing
  always_ff @(negedge sclk or posedge frame_n)
  begin
    if (frame_n)
    begin
      cnt_r <= 5'h00;
      shift_r <= '0;
    end
    else if (cnt_r < 5'(WORD_BITS))
    begin
      shift_r <= {shift_r[WORD_BITS-2:0], data_in};
      cnt_r <= cnt_r + 5'h01;
    end
  end

  // word is only taken on the last edge, so an early frame end leaves nothing behind
  always_ff @(negedge sclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      word_hold <= '0;
      done_tgl <= 1'b0;
    end
    else if (cnt_r == 5'(WORD_BITS - 1))
    begin
      word_hold <= {shift_r[WORD_BITS-2:0], data_in};
      done_tgl <= ~done_tgl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // readback bit changes on the rising edge, host takes it on the falling edge
  always_ff @(posedge sclk or posedge frame_n)
  begin
    if (frame_n)
      serial_out <= 1'b0;
    else if (cnt_r < 5'(WORD_BITS))
      serial_out <= rb_word[5'(WORD_BITS - 1) - cnt_r];
    else
      serial_out <= 1'b0;
  end
endmodule : dscp_link_rx
`default_nettype wire

// ===== logic/dscp_calc_pacer.sv
// pacing of the shared calibration calculator
`timescale 1ns/1ps
`default_nettype none
`include "dscp_regs.svh"
module dscp_calc_pacer #(
  parameter int unsigned ST1_CYC = `DSCP_CYC_MIN(`DSCP_T_STAGE1_NS),
  parameter int unsigned ST2_CYC = `DSCP_CYC_MIN(`DSCP_T_STAGE2_NS),
  parameter int unsigned ST3_CYC = `DSCP_CYC_MIN(`DSCP_T_STAGE3_NS)
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [5:0] nchan,
  output logic busy_n
);
  dscp_pkg::dscp_calc_state_t state_r;
  logic [7:0] pend_r;
  logic [7:0] pend_nxt;
  logic [9:0] tmr_r;
  logic tmr_end;

  assign tmr_end = (tmr_r == 10'h000);

  // channels still owed a stage-one slot, from the starting write and any writes that land while the engine runs
  always_comb
  begin
    pend_nxt = pend_r;
    if (state_r == dscp_pkg::DSCP_CALC_ST1 && tmr_end && pend_r != 8'h00)
      pend_nxt = pend_r - 8'h01;
    if (start)
      pend_nxt = pend_nxt + {2'h0, nchan};
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      pend_r <= 8'h00;
    else
      pend_r <= pend_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // stage one repeats once per channel, then two and three run once
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= dscp_pkg::DSCP_CALC_IDLE;
      tmr_r <= 10'h000;
    end
    else
    begin
      case (state_r)
        dscp_pkg::DSCP_CALC_IDLE:
        begin
          if (start)
          begin
            state_r <= dscp_pkg::DSCP_CALC_ST1;
            tmr_r <= 10'(ST1_CYC - 1);
          end
        end
        dscp_pkg::DSCP_CALC_ST1:
        begin
          if (!tmr_end)
            tmr_r <= tmr_r - 10'h001;
          else if (pend_nxt != 8'h00)
            tmr_r <= 10'(ST1_CYC - 1);
          else
          begin
            state_r <= dscp_pkg::DSCP_CALC_ST2;
            tmr_r <= 10'(ST2_CYC - 1);
          end
        end
        dscp_pkg::DSCP_CALC_ST2:
        begin
          if (!tmr_end)
            tmr_r <= tmr_r - 10'h001;
          else
          begin
            state_r <= dscp_pkg::DSCP_CALC_ST3;
            tmr_r <= 10'(ST3_CYC - 1);
          end
        end
        dscp_pkg::DSCP_CALC_ST3:
        begin
          if (!tmr_end)
            tmr_r <= tmr_r - 10'h001;
          else if (pend_nxt != 8'h00)
          begin
            state_r <= dscp_pkg::DSCP_CALC_ST1;
            tmr_r <= 10'(ST1_CYC - 1);
          end
          else
            state_r <= dscp_pkg::DSCP_CALC_IDLE;
        end
        default:
          state_r <= dscp_pkg::DSCP_CALC_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      busy_n <= 1'b1;
    else
      busy_n <= (state_r == dscp_pkg::DSCP_CALC_IDLE) && !start ||
                (state_r == dscp_pkg::DSCP_CALC_ST3 && tmr_end && pend_nxt == 8'h00 && !start);
  end
endmodule : dscp_calc_pacer
`default_nettype wire

// ===== logic/dscp_dac_serial_port.sv
// serial command port of a 40-channel dac: decode, register store, readback
`timescale 1ns/1ps
`default_nettype none
`include "dscp_regs.svh"
//
// Contract
// - interface-select pin low picks single-ended, high picks differential; host holds it fixed.
// - interface wakes fully only at the falling edge of frame select.
// - word is mode 23..22, address 21..16, data 15..2, reserved 1..0.
// - host writes reserved bits zero; readback returns them as zero.
// - frame select falling starts a write; 24 falling clock edges precede its rise.
// - serial input sampled on each falling shift-clock edge.
// - frame ending before the 24th edge aborts and changes no register.
// - after frame select rises, clock edges are ignored until the next frame.
// - calibrated and output registers are not writable; input, offset, gain writes start recomputation.
// - mode 00 readback select word; register shifts out during the next transfer.
// - serial output floats until a read command, driven until data shifted out.
// - differential mode has no readback, serial output unused, inputs received as pairs.
// - burst and continuous clocks both work, same framing on both interfaces.
// - calibrated value computed in stages of 500, 500 and 250 ns.
// - multi-channel write repeats stage one per channel; host waits that total.
// - mode 11 input (A or B by bank bit), 10 offset, 01 gain, 00 special.
// - non-special modes write the data field to the addressed channels.
// - address can pick one channel, a group, a channel across groups, or all.
// - upper/lower address fields decode groups and channels per the addressing table.
// - special code 0 no-op, 1 control bits, 5 readback select.
// - codes 2-4 offset dacs, 6-10 bank-select bytes, 11 all bank bytes.
module dscp_dac_serial_port (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic if_select,
  input wire logic frame_n,
  input wire logic frame_n_c,
  input wire logic serial_in,
  input wire logic serial_in_c,
  output logic serial_out,
  output logic serial_out_oe,
  output logic link_awake,
  output logic calc_busy_n,
  output logic bank_select_field,
  output logic thermal_shutdown_enable,
  output logic soft_powerdown,
  output logic [13:0] span_offset_dac_0,
  output logic [13:0] span_offset_dac_1,
  output logic [13:0] span_offset_dac_2,
  output logic [39:0] bank_select_bits
);
  localparam int unsigned WB = `DSCP_WORD_BITS;
  localparam int unsigned NCH = `DSCP_NUM_CHAN;

  ////////////////////////////////////////////////////////////////////////////////
  // channel mask for the six address bits; index is group * 8 + channel
  function automatic logic [39:0] chan_mask(input logic [5:0] addr);
    logic [2:0] up;
    logic [2:0] lo;
    logic [39:0] m;
    up = addr[5:3];
    lo = addr[2:0];
    m = 40'h00_0000_0000;
    for (int g = 0; g < `DSCP_NUM_GROUP; g++)
    begin
      for (int c = 0; c < `DSCP_GROUP_CHAN; c++)
      begin
        if ((up == 3'h0 && (lo == 3'h0 || 32'(lo) == g + 1)) ||
            (32'(lo) == c && ((up <= 3'h5 && 32'(up) == g + 1) || up == 3'h6 || (up == 3'h7 && g != 0))))
          m[g * 8 + c] = 1'b1;
      end
    end
    return m;
  endfunction : chan_mask
  function automatic logic [5:0] count_ones(input logic [39:0] m);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 40; i++)
      n = n + {5'h00, m[i]};
    return n;
  endfunction : count_ones

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic sel_s1;
  logic sel_s2;
  logic frm_s1;
  logic frm_s2;
  logic tgl_s1;
  logic tgl_s2;
  logic tgl_s3;
  logic diff_mode;
  logic link_frame_n;
  logic link_data;
  logic done_tgl;
  logic [23:0] word_hold;
  logic [23:0] rb_word_r;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sel_s1 <= 1'b0;
      sel_s2 <= 1'b0;
      frm_s1 <= 1'b1;
      frm_s2 <= 1'b1;
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end
    else
    begin
      sel_s1 <= if_select;
      sel_s2 <= sel_s1;
      frm_s1 <= link_frame_n;
      frm_s2 <= frm_s1;
      tgl_s1 <= done_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  assign diff_mode = sel_s2;
  // pairs resolve to a frame only while both legs agree it is active
  assign link_frame_n = diff_mode ? (frame_n | ~frame_n_c) : frame_n;
  assign link_data = diff_mode ? (serial_in & ~serial_in_c) : serial_in;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      link_awake <= 1'b0;
    else
      link_awake <= ~frm_s2;
  end
  // rb_word_r only changes after a word completes, so it is still when the next frame reads it
  dscp_link_rx #(
    .WORD_BITS(WB)
  ) u_link (
    .sclk(sclk),
    .rst_b(rst_b),
    .frame_n(link_frame_n),
    .data_in(link_data),
    .rb_word(rb_word_r),
    .word_hold(word_hold),
    .done_tgl(done_tgl),
    .serial_out(serial_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // word decode in the mclk domain
  logic word_evt;
  logic [1:0] mode;
  logic [5:0] addr;
  logic [13:0] data;
  logic [15:0] func;
  logic [39:0] mask;
  logic is_special;
  assign word_evt = tgl_s2 ^ tgl_s3;
  assign mode = word_hold[`DSCP_MODE_HI:`DSCP_MODE_LO];
  assign addr = word_hold[`DSCP_ADDR_HI:`DSCP_ADDR_LO];
  assign data = word_hold[`DSCP_DATA_HI:`DSCP_DATA_LO];
  assign func = word_hold[`DSCP_FUNC_HI:`DSCP_FUNC_LO];
  assign mask = chan_mask(addr);
  assign is_special = (mode == `DSCP_MODE_SPECIAL);

  ////////////////////////////////////////////////////////////////////////////////
  // per-channel stores; calibrated and output registers live elsewhere and take no writes
  logic [13:0] input_reg_a [NCH];
  logic [13:0] input_reg_b [NCH];
  logic [13:0] offset_reg [NCH];
  logic [13:0] gain_reg [NCH];

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        input_reg_a[i] <= `DSCP_INPUT_RST;
        input_reg_b[i] <= `DSCP_INPUT_RST;
        offset_reg[i] <= `DSCP_OFFSET_RST;
        gain_reg[i] <= `DSCP_GAIN_RST;
      end
    end
    else if (word_evt && !is_special)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (mask[i])
        begin
          case (mode)
            `DSCP_MODE_INPUT:
            begin
              if (bank_select_field)
                input_reg_b[i] <= data;
              else
                input_reg_a[i] <= data;
            end
            `DSCP_MODE_OFFSET: offset_reg[i] <= data;
            `DSCP_MODE_GAIN: gain_reg[i] <= data;
            default: ;
          endcase
        end
      end
    end
  end

  // any store write starts the calculator, one stage-one slot per channel
  dscp_calc_pacer u_calc (
    .mclk(mclk),
    .rst_b(rst_b),
    .start(word_evt && !is_special && mask != 40'h00_0000_0000),
    .nchan(count_ones(mask)),
    .busy_n(calc_busy_n)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // special functions
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bank_select_field <= 1'b0;
      thermal_shutdown_enable <= 1'b0;
      soft_powerdown <= 1'b0;
    end
    else if (word_evt && is_special && addr == `DSCP_FN_CTRL)
    begin
      bank_select_field <= func[`DSCP_CTRL_BANK_BIT];
      thermal_shutdown_enable <= func[`DSCP_CTRL_THERM_BIT];
      soft_powerdown <= func[`DSCP_CTRL_PD_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      span_offset_dac_0 <= `DSCP_OFSDAC_RST;
      span_offset_dac_1 <= `DSCP_OFSDAC_RST;
      span_offset_dac_2 <= `DSCP_OFSDAC_RST;
    end
    else if (word_evt && is_special)
    begin
      if (addr == `DSCP_FN_SPAN_OFFSET_DAC_0)
        span_offset_dac_0 <= func[13:0];
      if (addr == `DSCP_FN_SPAN_OFFSET_DAC_0 + 6'h01)
        span_offset_dac_1 <= func[13:0];
      if (addr == `DSCP_FN_SPAN_OFFSET_DAC_2)
        span_offset_dac_2 <= func[13:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      bank_select_bits <= 40'h00_0000_0000;
    else if (word_evt && is_special)
    begin
      for (int g = 0; g < `DSCP_NUM_GROUP; g++)
      begin
        if (addr == `DSCP_FN_ABSEL0 + 6'(g))
          bank_select_bits[g * 8 +: 8] <= func[7:0];
        else if (addr == `DSCP_FN_ABSEL_ALL)
          bank_select_bits[g * 8 +: 8] <= (func[7:0] == 8'h00) ? 8'h00 : 8'hff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // readback: the select word loads the reply, the next completed word releases the pin
  logic [2:0] rb_type;
  logic [5:0] rb_code;
  logic [5:0] rb_idx;
  logic rb_chan_ok;
  logic [13:0] rb_val;
  logic rb_cmd;
  logic rb_pending_r;
  assign rb_type = func[`DSCP_RB_TYPE_HI:`DSCP_RB_TYPE_LO];
  assign rb_code = func[`DSCP_RB_CHAN_HI:`DSCP_RB_CHAN_LO];
  assign rb_idx = rb_code - `DSCP_RB_CHAN_BASE;
  assign rb_chan_ok = (rb_code >= `DSCP_RB_CHAN_BASE) && (32'(rb_idx) < NCH);
  assign rb_cmd = word_evt && is_special && addr == `DSCP_FN_READBACK;
  always_comb
  begin
    rb_val = 14'h0000;
    case (rb_type)
      3'(dscp_pkg::DSCP_RB_A): rb_val = rb_chan_ok ? input_reg_a[rb_idx] : 14'h0000;
      3'(dscp_pkg::DSCP_RB_B): rb_val = rb_chan_ok ? input_reg_b[rb_idx] : 14'h0000;
      3'(dscp_pkg::DSCP_RB_C): rb_val = rb_chan_ok ? offset_reg[rb_idx] : 14'h0000;
      3'(dscp_pkg::DSCP_RB_M): rb_val = rb_chan_ok ? gain_reg[rb_idx] : 14'h0000;
      3'(dscp_pkg::DSCP_RB_SPEC):
      begin
        if (rb_code == 6'h00)
          rb_val = {11'h000, bank_select_field, thermal_shutdown_enable, soft_powerdown};
        else if (rb_code == `DSCP_RB_SPEC_SPAN_OFFSET_DAC_0)
          rb_val = span_offset_dac_0;
        else if (rb_code == `DSCP_RB_SPEC_SPAN_OFFSET_DAC_0 + 6'h01)
          rb_val = span_offset_dac_1;
        else if (rb_code == `DSCP_RB_SPEC_SPAN_OFFSET_DAC_0 + 6'h02)
          rb_val = span_offset_dac_2;
        else if (rb_code >= `DSCP_RB_SPEC_ABSEL0 && rb_code < `DSCP_RB_SPEC_ABSEL0 + 6'h05)
          rb_val = {6'h00, bank_select_bits[(rb_code - `DSCP_RB_SPEC_ABSEL0) * 8 +: 8]};
        else
          rb_val = 14'h0000;
      end
      default: rb_val = 14'h0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      rb_word_r <= 24'h00_0000;
    else if (rb_cmd)
      rb_word_r <= {8'h00, rb_val, {`DSCP_RSVD_BITS{1'b0}}};
  end

  // an aborted frame is no word, so the reply stays armed for the next full one
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      rb_pending_r <= 1'b0;
    else if (word_evt)
      rb_pending_r <= rb_cmd && !diff_mode;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      serial_out_oe <= 1'b0;
    else
      serial_out_oe <= rb_pending_r && !diff_mode;
  end
endmodule : dscp_dac_serial_port
`default_nettype wire

// ===== test/dscp_chk.sv
// assertion checker for the dac serial command port
`timescale 1ns/1ps
`default_nettype none
module dscp_chk (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic if_select,
  input wire logic frame_n,
  input wire logic frame_n_c,
  input wire logic serial_out_oe,
  input wire logic link_awake,
  input wire logic calc_busy_n,
  input wire logic bank_select_field,
  input wire logic soft_powerdown,
  input wire logic [13:0] span_offset_dac_0,
  input wire logic [39:0] bank_select_bits
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  logic [12:0] busy_cnt_r;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      busy_cnt_r <= 13'h0000;
    else if (calc_busy_n)
      busy_cnt_r <= 13'h0000;
    else
      busy_cnt_r <= busy_cnt_r + 13'h0001;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // offset dac 0, bank bits, bank and powerdown control bits, busy start and readback enable move only after a word in an open frame;
  // link wake, no differential readback, busy length
  diff_no_rb_a: assert property (if_select && $past(if_select, 8) |-> !serial_out_oe)
    else $error("serial output enabled in differential mode");
  wake_frame_a: assert property ((!frame_n && frame_n_c) [*6] |-> link_awake)
    else $error("link asleep inside a frame");
  sleep_idle_a: assert property (frame_n [*6] |-> !link_awake)
    else $error("link awake outside a frame");
  busy_min_a: assert property ($rose(calc_busy_n) |-> busy_cnt_r >= 13'h00fa)
    else $error("calculator busy shorter than three stages");
  busy_cause_a: assert property ($fell(calc_busy_n) |-> $past(link_awake, 8))
    else $error("calculator started without a word");
  rb_cause_a: assert property ($rose(serial_out_oe) |-> $past(link_awake, 8) && !if_select)
    else $error("serial output enabled without a command");
  ofs_cause_a: assert property ($changed(span_offset_dac_0) |-> $past(link_awake, 8))
    else $error("offset dac changed without a word");
  bank_cause_a: assert property ($changed(bank_select_bits) |-> $past(link_awake, 8))
    else $error("bank bits changed without a word");
  ctrl_cause_a: assert property ($changed({bank_select_field, soft_powerdown}) |-> $past(link_awake, 8))
    else $error("control bits changed without a word");
  cover property ($rose(serial_out_oe));
  cover property ($rose(calc_busy_n) && busy_cnt_r >= 13'h1036);
  cover property (if_select && link_awake);
endmodule : dscp_chk
bind dscp_dac_serial_port dscp_chk dscp_chk_inst (.mclk, .rst_b, .if_select, .frame_n, .frame_n_c,
  .serial_out_oe, .link_awake, .calc_busy_n, .bank_select_field, .soft_powerdown, .span_offset_dac_0,
  .bank_select_bits);
`default_nettype wire

// ===== test/dscp_host_model.sv
// host serial master model driving the link pins
`timescale 1ns/1ps
`default_nettype none
module dscp_host_model (
  input wire logic idle_hi,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  output logic sclk,
  output logic frame_n,
  output logic frame_n_c,
  output logic serial_in,
  output logic serial_in_c
);
  // 125 ns shift clock, stopped between frames
  localparam realtime HALF = 62.5;
  initial
  begin
    sclk = 1'b0;
    frame_n = 1'b1;
    frame_n_c = 1'b0;
    serial_in = 1'b0;
    serial_in_c = 1'b1;
  end
  task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] r);
    r = 24'h000000;
    sclk = idle_hi;
    #13.7;
    frame_n = 1'b0;
    frame_n_c = 1'b1;
    #HALF;
    for (int i = 0; i < n; i++)
    begin
      serial_in = w[23-i];
      serial_in_c = ~w[23-i];
      if (!idle_hi)
        sclk = 1'b1;
      #HALF;
      sclk = 1'b0;
      r = {r[22:0], serial_out_oe ? serial_out : 1'bx};
      #HALF;
      if (idle_hi)
        sclk = 1'b1;
    end
    // gated clock, so the frame may close at once; released data shows the inverse
    frame_n = 1'b1;
    frame_n_c = 1'b0;
    serial_in = ~serial_in;
    serial_in_c = ~serial_in_c;
    #120;
  endtask : xfer
endmodule : dscp_host_model
`default_nettype wire

// ===== test/dscp_dac_serial_port_tb.sv
// self-checking bench for the dac serial command port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
    end \
  end
module dscp_dac_serial_port_tb;
  logic mclk = 1'b0;
  logic rst_b, if_select, sclk, frame_n, frame_n_c, serial_in, serial_in_c, serial_out, serial_out_oe;
  logic link_awake, calc_busy_n, bank_select_field, thermal_shutdown_enable, soft_powerdown;
  logic [13:0] span_offset_dac_0, span_offset_dac_1, span_offset_dac_2;
  logic [39:0] bank_select_bits;
  logic [23:0] rep;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int bcur = 0;
  int blen = 0;
  always #2.5 mclk = ~mclk;
  dscp_dac_serial_port dscp_dac_serial_port_inst (.mclk, .rst_b, .sclk, .if_select, .frame_n, .frame_n_c,
    .serial_in, .serial_in_c, .serial_out, .serial_out_oe, .link_awake, .calc_busy_n, .bank_select_field,
    .thermal_shutdown_enable, .soft_powerdown, .span_offset_dac_0, .span_offset_dac_1, .span_offset_dac_2,
    .bank_select_bits);
  dscp_host_model dscp_host_model_inst (.idle_hi(if_select), .serial_out, .serial_out_oe, .sclk, .frame_n,
    .frame_n_c, .serial_in, .serial_in_c);
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  // busy pulse length in mclk cycles, plus the hang limit
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (calc_busy_n === 1'b0)
      bcur <= bcur + 1;
    else if (bcur != 0)
    begin
      blen <= bcur;
      bcur <= 0;
    end
    if (cyc == 60000)
    begin
      err_count++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic do_reset(input logic sel);
    @(posedge mclk);
    rst_b <= 1'b0;
    if_select <= sel;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask : do_reset
  function automatic logic [23:0] wd(input logic [1:0] m, input logic [5:0] a, input logic [15:0] f);
    return {m, a, f};
  endfunction : wd
  task automatic send(input logic [23:0] w);
    dscp_host_model_inst.xfer(w, 24, rep);
  endtask : send
  // host waits out the calculator before the next write
  task automatic wait_idle();
    for (int k = 0; k < 6000 && calc_busy_n !== 1'b1; k++)
      @(posedge mclk);
    repeat (3) @(posedge mclk);
  endtask : wait_idle
  task automatic t_special();
    logic [41:0] e;
    logic [39:0] b;
    `CHK("ctrl", 3'h0, {bank_select_field, thermal_shutdown_enable, soft_powerdown})
    `CHK("busy", 1'b1, calc_busy_n)
    `CHK("oe", 1'b0, serial_out_oe)
    send(wd(2'h0, 6'h01, 16'hfffd));
    `CHK("ctrl", 3'h5, {bank_select_field, thermal_shutdown_enable, soft_powerdown})
    send(wd(2'h0, 6'h01, 16'h0002));
    `CHK("ctrl", 3'h2, {bank_select_field, thermal_shutdown_enable, soft_powerdown})
    for (int i = 0; i < 3; i++)
    begin
      e[i*14 +: 14] = 14'h1a5c ^ 14'(i);
      send(wd(2'h0, 6'h02 + 6'(i), {2'h3, e[i*14 +: 14]}));
    end
    `CHK("ofs", e, {span_offset_dac_2, span_offset_dac_1, span_offset_dac_0})
    for (int g = 0; g < 5; g++)
    begin
      b[g*8 +: 8] = 8'h11 * 8'(g + 1);
      send(wd(2'h0, 6'h06 + 6'(g), {8'hff, b[g*8 +: 8]}));
    end
    `CHK("bank", b, bank_select_bits)
    send(wd(2'h0, 6'h0b, 16'h0001));
    `CHK("bank all", 40'hffffffffff, bank_select_bits)
    send(wd(2'h0, 6'h0b, 16'h0000));
    send(24'h000000);
    `CHK("bank nop", 40'h0000000000, bank_select_bits)
    dscp_host_model_inst.xfer(wd(2'h0, 6'h02, 16'h0777), 23, rep);
    `CHK("ofs abort", e[13:0], span_offset_dac_0)
    send(wd(2'h0, 6'h02, 16'h0123));
    `CHK("ofs after abort", 14'h0123, span_offset_dac_0)
    send(wd(2'h0, 6'h02, {2'h0, e[13:0]}));
    $display("test special done");
  endtask : t_special
  task automatic t_calc();
    logic [7:0] ad [6] = '{8'hca, 8'h81, 8'h70, 8'hf8, 8'h80, 8'hc6};
    int len [6] = '{250, 950, 650, 550, 4150, 0};
    for (int i = 0; i < 6; i++)
    begin
      blen = 0;
      send({ad[i], 14'h0100 + 14'(i), 2'h0});
      wait_idle();
      `CHK("busy len", len[i], blen)
    end
    $display("test calc done");
  endtask : t_calc
  task automatic t_readback();
    // the last two read the control register and offset dac 0 through the special readback codes
    logic [15:0] sel [10] = '{16'h0500, 16'h6800, 16'h6480, 16'h5780, 16'h0400, 16'h8100, 16'h2500, 16'h0500,
      16'h8000, 16'h8080};
    logic [13:0] v [10] = '{14'h0100, 14'h0102, 14'h3fff, 14'h0104, 14'h0000, 14'h1a5d, 14'h2222, 14'h0100,
      14'h0004, 14'h1a5c};
    for (int i = 0; i < 10; i++)
    begin
      if (i == 6)
      begin
        send(wd(2'h0, 6'h01, 16'h0004));
        send({8'hca, 14'h2222, 2'h0});
        wait_idle();
      end
      send(wd(2'h0, 6'h05, sel[i]));
      repeat (20) @(posedge mclk);
      `CHK("oe on", 1'b1, serial_out_oe)
      send(24'h000000);
      `CHK("reply", {8'h00, v[i], 2'h0}, rep)
      `CHK("oe off", 1'b0, serial_out_oe)
    end
    $display("test readback done");
  endtask : t_readback
  task automatic t_diff();
    do_reset(1'b1);
    send(wd(2'h0, 6'h01, 16'h0007));
    `CHK("diff ctrl", 3'h7, {bank_select_field, thermal_shutdown_enable, soft_powerdown})
    send(wd(2'h0, 6'h05, 16'h0500));
    repeat (20) @(posedge mclk);
    `CHK("diff oe", 1'b0, serial_out_oe)
    $display("test diff done");
  endtask : t_diff
  initial
  begin
    rst_b = 1'b0;
    if_select = 1'b0;
    do_reset(1'b0);
    t_special();
    t_calc();
    t_readback();
    t_diff();
    final_report();
  end
endmodule : dscp_dac_serial_port_tb
`default_nettype wire
